// file: pkg/bcts_pkg.sv
// constants, types and decode helpers for the branch, call and table sequencer
package bcts_pkg;

  // ****************************************
  // widths and reset values
  // ****************************************
  localparam int             PC_W        = 17;
  localparam int             TPTR_W      = 23;
  localparam logic [16:0]    PC_RESET    = 17'h00000;
  localparam logic [22:0]    TPTR_RESET  = 23'h000000;

  // ****************************************
  // opcode fields
  // ****************************************
  localparam logic [7:0]     OP_GE_K     = 8'h47;
  localparam logic [7:0]     OP_LE_K     = 8'h48;
  localparam logic [7:0]     OP_EQ_K     = 8'h49;
  localparam logic [7:0]     OP_GE_R     = 8'h55;
  localparam logic [7:0]     OP_LE_R     = 8'h56;
  localparam logic [7:0]     OP_EQ_R     = 8'h57;
  localparam logic [11:0]    OP_LONG_JUMP  = 12'h002;
  localparam logic [11:0]    OP_LONG_CALL  = 12'h003;
  localparam logic [2:0]     OP_SHORT_JUMP = 3'h6;
  localparam logic [2:0]     OP_SHORT_CALL = 3'h7;
  localparam logic [3:0]     OP_PAGE0_CALL = 4'h3;
  localparam logic [15:0]    OP_SUB_RETURN = 16'h2bfe;
  localparam logic [15:0]    OP_INT_RETURN = 16'h2bff;
  localparam logic [5:0]     OP_TABLE_READ = 6'h0b;
  localparam logic [7:0]     OP_TP_LOW   = 8'h40;
  localparam logic [7:0]     OP_TP_MID   = 8'h41;
  localparam logic [7:0]     OP_TP_HIGH  = 8'h42;
  localparam logic [7:0]     OP_ADD_RA   = 8'h11;

  // table pointer read modes: keep, increment or decrement after read, or A-indexed
  localparam logic [1:0]     TP_KEEP     = 2'h0;
  localparam logic [1:0]     TP_INC      = 2'h1;
  localparam logic [1:0]     TP_DEC      = 2'h2;
  localparam logic [1:0]     TP_ACC      = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_EXEC, ST_WORD2, ST_TABLE, ST_FLUSH} bcts_state_t;
  typedef enum logic [1:0] {W2_CMP, W2_LONG_JUMP, W2_LONG_CALL} bcts_word2_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [16:0] data;
  } bcts_stack_t;

  typedef struct packed {
    logic        we;
    logic [7:0]  dest;
    logic [7:0]  data;
  } bcts_table_t;

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic is_cmp_jump(input logic [15:0] w);
    is_cmp_jump = (w[15:8] == OP_GE_K) || (w[15:8] == OP_LE_K) || (w[15:8] == OP_EQ_K) ||
                  (w[15:8] == OP_GE_R) || (w[15:8] == OP_LE_R) || (w[15:8] == OP_EQ_R);
  endfunction

  function automatic logic is_reg_cmp(input logic [15:0] w);
    is_reg_cmp = (w[15:8] == OP_GE_R) || (w[15:8] == OP_LE_R) || (w[15:8] == OP_EQ_R);
  endfunction

endpackage

// file: hdl/bcts_byte_addsub.sv
// 8-bit adder and subtractor, carry set on subtract means no borrow
`timescale 1ns/1ps
`default_nettype none
module bcts_byte_addsub (
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       sub,
  output logic      [7:0] sum,
  output logic            carry
);

  logic [8:0] total;

  // subtract is a plus inverted b plus one: borrow shows as carry cleared [RULE_15]
  always_comb begin
    total = {1'b0, a} + {1'b0, (sub ? ~b : b)} + {8'h00, sub};
    sum   = total[7:0];
    carry = total[8];
  end

endmodule
`default_nettype wire

// file: hdl/bcts_sequencer.sv
// program counter, call, return and table read sequencer
//
// How it works
// RULE_01 - immediate compare-and-jump: compare A with k, load PC[15:0], two cycles, no flags.
// RULE_02 - register compare-and-jump: compare A with file register, load PC[15:0], two cycles.
// RULE_03 - short jump loads PC[12:0] from field, upper bits kept, one cycle.
// RULE_04 - long jump takes two words, loads the whole PC, two cycles.
// RULE_05 - page-zero call pushes PC+1, loads PC[11:0], clears upper bits, one cycle.
// RULE_06 - short call pushes PC+1, loads PC[12:0], keeps upper bits, one cycle.
// RULE_07 - long call takes two words, pushes PC+2 (the address after the second word), loads the whole PC.
// RULE_08 - both returns reload PC from stack top; interrupt return also enables interrupts.
// RULE_09 - table read pointer field: 00 keep, 01 increment, 10 decrement after read.
// RULE_10 - pointer is high:mid:low bytes; bit 0 picks low or high ROM byte.
// RULE_11 - table pointer spans eight megabytes of internal ROM.
// RULE_12 - sixteen-bit jump targets replace PC[15:0] only, staying in the 64K region.
// RULE_13 - adding A to PC low byte or pointer low byte carries into middle byte.
// RULE_14 - an instruction writing the PC as destination takes two cycles.
// RULE_15 - on subtract a cleared carry means a borrow happened.
// RULE_16 - greater-equal and less-equal compare unsigned; equality satisfies both.
`timescale 1ns/1ps
`default_nettype none
module bcts_sequencer #(
  parameter logic [7:0] PC_LOW_REG_ADDR = 8'h02,
  parameter logic [7:0] TPL_REG_ADDR = 8'h03
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [15:0] INSTR,
  input  wire logic [7:0]  ACC,
  input  wire logic [7:0]  FREG,
  input  wire logic [16:0] STACK_TOP,
  input  wire logic [15:0] ROM_WORD,
  output logic      [16:0] PC_ADDR,
  output logic      [22:0] TBL_POINTER,
  output logic      [21:0] TBL_WORD_ADDR,
  output logic             TBL_RD,
  output logic             TBL_WE,
  output logic      [7:0]  TBL_DEST,
  output logic      [7:0]  TBL_DATA,
  output logic             PUSH,
  output logic             POP,
  output logic      [16:0] PUSH_DATA,
  output logic             INT_ENABLE
);

  // ****************************************
  // state
  // ****************************************
  bcts_pkg::bcts_state_t next_state, state;
  bcts_pkg::bcts_word2_t next_w2, w2;
  bcts_pkg::bcts_stack_t next_stk, stk;
  bcts_pkg::bcts_table_t next_tbl, tbl;
  logic [16:0] next_pc, pc;
  logic [22:0] next_tptr, tptr;
  logic [21:0] next_tbl_word, tbl_word;
  logic [1:0]  next_tbl_mode, tbl_mode;
  logic        next_tbl_sel, tbl_sel;
  logic        next_tbl_rd, tbl_rd;
  logic        next_cond, cond;
  logic        next_hi, hi;
  logic        next_int_en, int_en;

  logic [7:0]  add_b;
  logic        add_sub;
  logic [7:0]  add_sum;
  logic        add_carry;
  logic [16:0] pc_inc;
  logic [22:0] tbl_addr;
  logic        cmp_zero;

  bcts_byte_addsub u_addsub (
    .a     (ACC),
    .b     (add_b),
    .sub   (add_sub),
    .sum   (add_sum),
    .carry (add_carry)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb begin
    next_state    = state;
    next_w2       = w2;
    next_pc       = pc;
    next_tptr     = tptr;
    next_tbl_word = tbl_word;
    next_tbl_mode = tbl_mode;
    next_tbl_sel  = tbl_sel;
    next_tbl_rd   = 1'b0;
    next_cond     = cond;
    next_hi       = hi;
    next_int_en   = 1'b0;
    next_stk      = '{push: 1'b0, pop: 1'b0, data: stk.data};
    next_tbl      = '{we: 1'b0, dest: tbl.dest, data: tbl.data};
    pc_inc        = pc + 17'h00001;
    tbl_addr      = tptr;
    add_sub       = 1'b1;
    add_b         = bcts_pkg::is_reg_cmp(INSTR) ? FREG : INSTR[7:0];
    if (INSTR[15:8] == bcts_pkg::OP_ADD_RA && INSTR[7:0] == PC_LOW_REG_ADDR) begin
      add_sub = 1'b0;
      add_b   = pc[7:0];
    end else if (INSTR[15:8] == bcts_pkg::OP_ADD_RA && INSTR[7:0] == TPL_REG_ADDR) begin
      add_sub = 1'b0;
      add_b   = tptr[7:0];
    end
    cmp_zero = (add_sum == 8'h00);
    case (state)
      bcts_pkg::ST_EXEC: begin
        if (INSTR == bcts_pkg::OP_SUB_RETURN || INSTR == bcts_pkg::OP_INT_RETURN) begin
          next_pc      = STACK_TOP;                                      // [RULE_08]
          next_stk.pop = 1'b1;
          next_int_en  = (INSTR == bcts_pkg::OP_INT_RETURN);             // [RULE_08]
        end else if (INSTR[15:13] == bcts_pkg::OP_SHORT_JUMP) begin
          next_pc = {pc[16:13], INSTR[12:0]};                            // [RULE_03]
        end else if (INSTR[15:13] == bcts_pkg::OP_SHORT_CALL) begin
          next_stk = '{push: 1'b1, pop: 1'b0, data: pc_inc};             // [RULE_06]
          next_pc  = {pc[16:13], INSTR[12:0]};                           // [RULE_06]
        end else if (INSTR[15:12] == bcts_pkg::OP_PAGE0_CALL) begin
          next_stk = '{push: 1'b1, pop: 1'b0, data: pc_inc};             // [RULE_05]
          next_pc  = {5'h00, INSTR[11:0]};                               // [RULE_05]
        end else if (INSTR[15:4] == bcts_pkg::OP_LONG_JUMP) begin
          next_w2    = bcts_pkg::W2_LONG_JUMP;                           // [RULE_04]
          next_hi    = INSTR[0];
          next_pc    = pc_inc;
          next_state = bcts_pkg::ST_WORD2;
        end else if (INSTR[15:4] == bcts_pkg::OP_LONG_CALL) begin
          next_w2    = bcts_pkg::W2_LONG_CALL;                           // [RULE_07]
          next_hi    = INSTR[0];
          next_pc    = pc_inc;
          next_state = bcts_pkg::ST_WORD2;
        end else if (bcts_pkg::is_cmp_jump(INSTR)) begin
          // unsigned compare by subtraction, nothing flag-like is written [RULE_16]
          if (INSTR[15:8] == bcts_pkg::OP_GE_K || INSTR[15:8] == bcts_pkg::OP_GE_R) begin
            next_cond = add_carry;                                       // [RULE_15]
          end else if (INSTR[15:8] == bcts_pkg::OP_LE_K || INSTR[15:8] == bcts_pkg::OP_LE_R) begin
            next_cond = !add_carry || cmp_zero;                          // [RULE_16]
          end else begin
            next_cond = cmp_zero;                                        // [RULE_01] [RULE_02]
          end
          next_w2    = bcts_pkg::W2_CMP;
          next_pc    = pc_inc;
          next_state = bcts_pkg::ST_WORD2;
        end else if (INSTR[15:10] == bcts_pkg::OP_TABLE_READ) begin
          if (INSTR[9:8] == bcts_pkg::TP_ACC) begin
            tbl_addr = tptr + {15'h0000, ACC};
          end
          next_tbl_mode = INSTR[9:8];
          next_tbl.dest = INSTR[7:0];
          next_tbl_word = tbl_addr[22:1];                                // [RULE_11]
          next_tbl_sel  = tbl_addr[0];                                   // [RULE_10]
          next_tbl_rd   = 1'b1;
          next_pc       = pc_inc;
          next_state    = bcts_pkg::ST_TABLE;
        end else if (INSTR[15:8] == bcts_pkg::OP_TP_LOW) begin
          next_tptr = {tptr[22:8], INSTR[7:0]};                          // [RULE_10]
          next_pc   = pc_inc;
        end else if (INSTR[15:8] == bcts_pkg::OP_TP_MID) begin
          next_tptr = {tptr[22:16], INSTR[7:0], tptr[7:0]};              // [RULE_10]
          next_pc   = pc_inc;
        end else if (INSTR[15:8] == bcts_pkg::OP_TP_HIGH) begin
          next_tptr = {INSTR[6:0], tptr[15:0]};                          // [RULE_10]
          next_pc   = pc_inc;
        end else if (INSTR[15:8] == bcts_pkg::OP_ADD_RA && INSTR[7:0] == PC_LOW_REG_ADDR) begin
          next_pc    = {pc[16:8] + {8'h00, add_carry}, add_sum};         // [RULE_13]
          next_state = bcts_pkg::ST_FLUSH;                               // [RULE_14]
        end else if (INSTR[15:8] == bcts_pkg::OP_ADD_RA && INSTR[7:0] == TPL_REG_ADDR) begin
          next_tptr = {tptr[22:8] + {14'h0000, add_carry}, add_sum};     // [RULE_13]
          next_pc   = pc_inc;
        end else begin
          next_pc = pc_inc;
        end
      end
      bcts_pkg::ST_WORD2: begin
        case (w2)
          bcts_pkg::W2_LONG_JUMP: begin
            next_pc = {hi, INSTR};                                       // [RULE_04]
          end
          bcts_pkg::W2_LONG_CALL: begin
            next_stk = '{push: 1'b1, pop: 1'b0, data: pc_inc};           // [RULE_07]
            next_pc  = {hi, INSTR};                                      // [RULE_07]
          end
          default: begin
            next_pc = cond ? {pc[16], INSTR} : pc_inc;                   // [RULE_12]
          end
        endcase
        next_state = bcts_pkg::ST_EXEC;
      end
      bcts_pkg::ST_TABLE: begin
        next_tbl.we   = 1'b1;
        next_tbl.data = tbl_sel ? ROM_WORD[15:8] : ROM_WORD[7:0];        // [RULE_10]
        case (tbl_mode)
          bcts_pkg::TP_INC: next_tptr = tptr + 23'h000001;               // [RULE_09]
          bcts_pkg::TP_DEC: next_tptr = tptr - 23'h000001;               // [RULE_09]
          default:          next_tptr = tptr;                            // [RULE_09]
        endcase
        next_state = bcts_pkg::ST_EXEC;
      end
      default: begin
        next_state = bcts_pkg::ST_EXEC;
      end
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state    <= bcts_pkg::ST_EXEC;
      w2       <= bcts_pkg::W2_CMP;
      pc       <= bcts_pkg::PC_RESET;
      tptr     <= bcts_pkg::TPTR_RESET;
      tbl_word <= 22'h000000;
      tbl_mode <= bcts_pkg::TP_KEEP;
      tbl_sel  <= 1'b0;
      tbl_rd   <= 1'b0;
      cond     <= 1'b0;
      hi       <= 1'b0;
      int_en   <= 1'b0;
      stk      <= '0;
      tbl      <= '0;
    end else begin
      state    <= next_state;
      w2       <= next_w2;
      pc       <= next_pc;
      tptr     <= next_tptr;
      tbl_word <= next_tbl_word;
      tbl_mode <= next_tbl_mode;
      tbl_sel  <= next_tbl_sel;
      tbl_rd   <= next_tbl_rd;
      cond     <= next_cond;
      hi       <= next_hi;
      int_en   <= next_int_en;
      stk      <= next_stk;
      tbl      <= next_tbl;
    end
  end

  assign PC_ADDR       = pc;
  assign TBL_POINTER   = tptr;
  assign TBL_WORD_ADDR = tbl_word;
  assign TBL_RD        = tbl_rd;
  assign TBL_WE        = tbl.we;
  assign TBL_DEST      = tbl.dest;
  assign TBL_DATA      = tbl.data;
  assign PUSH          = stk.push;
  assign POP           = stk.pop;
  assign PUSH_DATA     = stk.data;
  assign INT_ENABLE    = int_en;

  // ****************************************
  // assertions
  // ****************************************
  property p_short_jump;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:13] == 3'h6)
      |=> (pc == {$past(pc[16:13]), $past(INSTR[12:0])}) && !PUSH;
  endproperty
  a_short_jump: assert property (p_short_jump) else $error("short jump target wrong"); // [RULE_03]

  property p_page_zero_call;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:12] == 4'h3)
      |=> PUSH && PUSH_DATA == $past(pc) + 17'h00001 && pc[16:12] == 5'h00;
  endproperty
  a_page_zero_call: assert property (p_page_zero_call) else $error("page zero call wrong"); // [RULE_05]

  property p_short_call;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:13] == 3'h7)
      |=> PUSH && pc == {$past(pc[16:13]), $past(INSTR[12:0])};
  endproperty
  a_short_call: assert property (p_short_call) else $error("short call wrong"); // [RULE_06]

  property p_return;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:1] == 15'h15ff)
      |=> POP && pc == $past(STACK_TOP) && INT_ENABLE == $past(INSTR[0]);
  endproperty
  a_return: assert property (p_return) else $error("return wrong"); // [RULE_08]

  property p_cmp_two_cycles;
    @(posedge CLK) disable iff (!RESETN)
      (RESETN && state == bcts_pkg::ST_EXEC && bcts_pkg::is_cmp_jump(INSTR))
      |=> state == bcts_pkg::ST_WORD2 ##1 state == bcts_pkg::ST_EXEC && !PUSH;
  endproperty
  a_cmp_two_cycles: assert property (p_cmp_two_cycles) else $error("compare jump length"); // [RULE_01]

  property p_cmp_target;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_WORD2 && w2 == bcts_pkg::W2_CMP && cond)
      |=> pc == {$past(pc[16]), $past(INSTR)};
  endproperty
  a_cmp_target: assert property (p_cmp_target) else $error("jump left 64K region"); // [RULE_12]

  property p_long_call;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:4] == 12'h003)
      |=> ##1 PUSH && PUSH_DATA == $past(pc, 2) + 17'h00002 && pc == {$past(INSTR[0], 2), $past(INSTR)};
  endproperty
  a_long_call: assert property (p_long_call) else $error("long call wrong"); // [RULE_07]

  property p_table_inc;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:8] == 8'h2d)
      |=> TBL_RD ##1 TBL_WE && tptr == $past(tptr, 2) + 23'h000001;
  endproperty
  a_table_inc: assert property (p_table_inc) else $error("table pointer not incremented"); // [RULE_09]

  property p_table_byte;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_TABLE)
      |=> TBL_DATA == ($past(tbl_sel) ? $past(ROM_WORD[15:8]) : $past(ROM_WORD[7:0]));
  endproperty
  a_table_byte: assert property (p_table_byte) else $error("table byte select wrong"); // [RULE_10]

  property p_pc_write_flush;
    @(posedge CLK) disable iff (!RESETN)
      (state == bcts_pkg::ST_EXEC && INSTR[15:8] == 8'h11 && INSTR[7:0] == PC_LOW_REG_ADDR)
      |=> state == bcts_pkg::ST_FLUSH && pc == $past(pc) + {9'h000, $past(ACC)};
  endproperty
  a_pc_write_flush: assert property (p_pc_write_flush) else $error("pc add wrong"); // [RULE_14]

endmodule
`default_nettype wire

// file: test/bcts_mem_model.sv
// behavioural program rom, table rom, file registers and return stack
`timescale 1ns/1ps
`default_nettype none
module bcts_mem_model (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [16:0] pc_addr,
  input  wire logic [21:0] tbl_word_addr,
  input  wire logic        tbl_rd,
  input  wire logic        tbl_we,
  input  wire logic [7:0]  tbl_dest,
  input  wire logic [7:0]  tbl_data,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [16:0] push_data,
  output logic      [15:0] instr,
  output logic      [7:0]  freg,
  output logic      [16:0] stack_top,
  output logic      [15:0] rom_word
);
  // ****************************************
  // storage
  // ****************************************
  logic [15:0] prog  [0:131071];
  logic [7:0]  regs  [0:255];
  logic [16:0] stk   [0:15];
  logic [15:0] noise;
  int          sp;

  // table rom contents, distinct bytes in each half of a word unless word address bits 21:14 are 8'h99
  function automatic logic [15:0] rom_of(input logic [21:0] w);
    rom_of = {w[7:0] ^ 8'h5a, w[7:0] ^ w[21:14] ^ 8'hc3};
  endfunction

  initial begin
    for (int i = 0; i < 131072; i++) begin
      prog[i] = 16'h0000;
    end
    for (int i = 0; i < 256; i++) begin
      regs[i] = 8'h00;
    end
    noise = 16'h0f0f;
    sp = 0;
  end

  // ****************************************
  // read paths
  // ****************************************
  assign instr = prog[pc_addr];
  assign freg = regs[instr[7:0]];
  // word-wide table rom over the whole pointer span, junk while idle
  assign rom_word = tbl_rd ? rom_of(tbl_word_addr) : noise;

  // stack top shows a pending push or pop at once, so a return right after a call sees it
  assign stack_top = push ? push_data :
                     (pop && sp > 1) ? stk[sp - 2] :
                     (!pop && sp > 0) ? stk[sp - 1] : {1'b1, ~noise};

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp <= 0;
    end else if (push) begin
      stk[sp[3:0]] <= push_data;
      sp <= sp + 1;
    end else if (pop && sp > 0) begin
      sp <= sp - 1;
    end
    if (resetn && tbl_we) begin
      regs[tbl_dest] <= tbl_data;
    end
    noise <= {noise[14:0], ~noise[15]};
  end
endmodule
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the branch, call and table sequencer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        resetn;
  logic [7:0]  acc;
  logic [15:0] instr;
  logic [7:0]  freg;
  logic [16:0] stack_top;
  logic [15:0] rom_word;
  logic [16:0] pc_addr;
  logic [22:0] tbl_pointer;
  logic [21:0] tbl_word_addr;
  logic        tbl_rd;
  logic        tbl_we;
  logic [7:0]  tbl_dest;
  logic [7:0]  tbl_data;
  logic        push;
  logic        pop;
  logic [16:0] push_data;
  logic        int_enable;
  int          failures;
  int          num_checks;

  bcts_sequencer dut (.CLK(clk), .RESETN(resetn), .INSTR(instr), .ACC(acc), .FREG(freg),
    .STACK_TOP(stack_top), .ROM_WORD(rom_word), .PC_ADDR(pc_addr), .TBL_POINTER(tbl_pointer),
    .TBL_WORD_ADDR(tbl_word_addr), .TBL_RD(tbl_rd), .TBL_WE(tbl_we), .TBL_DEST(tbl_dest),
    .TBL_DATA(tbl_data), .PUSH(push), .POP(pop), .PUSH_DATA(push_data),
    .INT_ENABLE(int_enable));

  bcts_mem_model model (.clk(clk), .resetn(resetn), .pc_addr(pc_addr),
    .tbl_word_addr(tbl_word_addr), .tbl_rd(tbl_rd), .tbl_we(tbl_we), .tbl_dest(tbl_dest),
    .tbl_data(tbl_data), .push(push), .pop(pop), .push_data(push_data), .instr(instr),
    .freg(freg), .stack_top(stack_top), .rom_word(rom_word));

  // ****************************************
  // helpers
  // ****************************************
  always #25 clk = ~clk;

  task automatic chk(input logic [22:0] got, input logic [22:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic put(input logic [16:0] a, input logic [15:0] w);
    model.prog[a] = w;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // short mid-run reset, first decode at the edge after release
  task automatic restart(input logic [7:0] a);
    @(posedge clk);
    resetn <= 1'b0;
    acc <= a;
    step(2);
    @(posedge clk);
    resetn <= 1'b1;
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_compare();
    logic [7:0] ops [6];
    logic [7:0] a;
    logic       hit;
    ops = '{8'h47, 8'h48, 8'h49, 8'h55, 8'h56, 8'h57};
    model.regs[8'h33] = 8'h80;
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 3; j++) begin
        a = 8'h7f + 8'(j);
        hit = (i % 3 == 0) ? (a >= 8'h80) : (i % 3 == 1) ? (a <= 8'h80) : (a == 8'h80);
        put(17'h00000, {ops[i], (i < 3) ? 8'h80 : 8'h33});
        put(17'h00001, 16'h1234);
        restart(a);
        step(1);
        chk(pc_addr, 17'h00001);
        step(1);
        chk(pc_addr, hit ? 17'h01234 : 17'h00002);
      end
    end
    $display("test_compare done");
  endtask

  task automatic test_flow();
    put(17'h00000, 16'h0021);
    put(17'h00001, 16'h0100);
    put(17'h10100, 16'h49aa);
    put(17'h10101, 16'h5555);
    put(17'h15555, 16'hcabc);
    put(17'h14abc, 16'hf234);
    put(17'h15234, 16'h3456);
    put(17'h00456, 16'h0031);
    put(17'h00457, 16'habcd);
    put(17'h1abcd, 16'h2bfe);
    put(17'h00458, 16'h2bff);
    put(17'h15235, 16'h2bff);
    put(17'h14abd, 16'h0000);
    restart(8'haa);
    step(1);
    chk(pc_addr, 17'h00001);
    step(1);
    chk(pc_addr, 17'h10100);
    step(2);
    chk(pc_addr, 17'h15555);
    step(1);
    chk(pc_addr, 17'h14abc);
    step(1);
    chk({push, pc_addr}, {1'b1, 17'h15234});
    chk(push_data, 17'h14abd);
    step(1);
    chk({push, pc_addr}, {1'b1, 17'h00456});
    chk(push_data, 17'h15235);
    step(1);
    chk({push, pc_addr}, {1'b0, 17'h00457});
    step(1);
    chk({push, pc_addr}, {1'b1, 17'h1abcd});
    chk(push_data, 17'h00458);
    step(1);
    chk({pop, int_enable, pc_addr}, {2'b10, 17'h00458});
    step(1);
    chk({pop, int_enable, pc_addr}, {2'b11, 17'h15235});
    step(1);
    chk({pop, int_enable, pc_addr}, {2'b11, 17'h14abd});
    step(1);
    chk({pop, int_enable, pc_addr}, {2'b00, 17'h14abe});
    $display("test_flow done");
  endtask

  task automatic test_add();
    put(17'h00000, 16'h0020);
    put(17'h00001, 16'hfff0);
    put(17'h0fff0, 16'h1102);
    put(17'h10010, 16'h40ff);
    put(17'h10011, 16'h4112);
    put(17'h10012, 16'h4205);
    put(17'h10013, 16'h1103);
    restart(8'h20);
    step(3);
    chk(pc_addr, 17'h10010);
    step(1);
    chk(pc_addr, 17'h10010);
    step(3);
    chk(tbl_pointer, 23'h0512ff);
    step(1);
    chk(tbl_pointer, 23'h05131f);
    chk(pc_addr, 17'h10014);
    $display("test_add done");
  endtask

  task automatic test_table();
    logic [22:0] from [4];
    logic [22:0] after [4];
    logic [15:0] w;
    from = '{23'h7f1235, 23'h7f1235, 23'h7f1236, 23'h7f1240};
    after = '{23'h7f1235, 23'h7f1236, 23'h7f1235, 23'h7f1235};
    put(17'h00000, 16'h4035);
    put(17'h00001, 16'h4112);
    put(17'h00002, 16'h427f);
    for (int k = 0; k < 4; k++) begin
      put(17'(3 + k), 16'h2c10 + 16'(k * 257));
    end
    restart(8'h0b);
    step(3);
    chk(tbl_pointer, 23'h7f1235);
    for (int k = 0; k < 4; k++) begin
      w = model.rom_of(from[k][22:1]);
      step(1);
      chk({tbl_rd, tbl_word_addr}, {1'b1, from[k][22:1]});
      step(1);
      chk({tbl_rd, tbl_we, tbl_dest}, {2'b01, 8'h10 + 8'(k)});
      chk(tbl_data, from[k][0] ? w[15:8] : w[7:0]);
      chk(tbl_pointer, after[k]);
    end
    chk(pc_addr, 17'h00007);
    $display("test_table done");
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    resetn = 1'b0;
    acc = 8'h00;
    failures = 0;
    num_checks = 0;
    repeat (20) @(posedge clk);
    #1;
    chk({push, pop, tbl_rd, tbl_we, pc_addr}, 21'h000000);
    chk(tbl_pointer, 23'h000000);
    test_compare();
    test_flow();
    test_add();
    test_table();
    complete_run();
  end

  initial begin
    #200000;
    failures++;
    complete_run();
  end
endmodule
`default_nettype wire
